// ### verilog/ddstl_host.sv
// The address map and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
module ddstl_host
   import ddstl_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   ddstl_if.host link
);
   // ----------------------------------------
   // Wishbone slave
   // ----------------------------------------
   logic ack_ff;
   logic [31:0] dat_ff;
   logic [CTRL_W-1:0] ctrl_ff;
   logic [31:0] word_ff;
   logic busy_ff;
   wire req = wb_cyc_i & wb_stb_i;
   wire wrNow = ack_ff & req & wb_we_i;
   wire hitCtrl = wb_adr_i == ADR_CTRL;
   wire hitWord = wb_adr_i == ADR_WORD;
   wire hitCmd = wb_adr_i == ADR_CMD;
   wire [31:0] rdMux = hitCtrl ? {{(32 - CTRL_W){1'b0}}, ctrl_ff} :
                       hitWord ? {1'b0, word_ff[30:0]} :
                       hitCmd ? {31'h0, busy_ff} : 32'h0;
   wire wrCtrl = wrNow & hitCtrl & wb_sel_i[0];
   wire go = wrNow & hitCmd & wb_sel_i[0] & wb_dat_i[CMD_GO] & ~busy_ff;
   logic [31:0] nxt_word;
   for (genvar b = 0; b < 4; b++) begin : g_lane
      assign nxt_word[8*b +: 8] = (wrNow & hitWord & wb_sel_i[b]) ? wb_dat_i[8*b +: 8] :
                                  word_ff[8*b +: 8];
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ack_ff <= 1'b0;
         dat_ff <= '0;
         ctrl_ff <= CTRL_RST_VAL;
         word_ff <= '0;
      end else begin
         ack_ff <= req & ~ack_ff;
         dat_ff <= (req & ~ack_ff) ? rdMux : dat_ff;
         ctrl_ff <= wrCtrl ? wb_dat_i[CTRL_W-1:0] : ctrl_ff;
         word_ff <= {1'b0, nxt_word[30:0]};
      end
   end
   assign wb_ack_o = ack_ff;
   assign wb_dat_o = dat_ff;

   // ----------------------------------------
   // Power-on reset pulse
   // ----------------------------------------
   logic [CNT_W-1:0] rstCnt_ff;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rstCnt_ff <= CNT_W'(RST_CYC);
      end else if (rstCnt_ff != '0) begin
         rstCnt_ff <= rstCnt_ff - 1'b1;
      end
   end

   // ----------------------------------------
   // Load sequencer
   // ----------------------------------------
   ddstl_hstate_e state_ff, nxt_state;
   logic [CNT_W-1:0] cnt_ff, nxt_cnt;
   logic [4:0] bit_ff, nxt_bit;
   logic [SER_BITS-1:0] sh_ff, nxt_sh;
   logic sclk_ff, nxt_sclk;
   logic win_ff, nxt_win;
   logic hop_ff, nxt_hop;
   logic nxt_busy;
   wire tick = cnt_ff == '0;
   wire lastBit = bit_ff == 5'(SER_BITS - 1);

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = tick ? cnt_ff : cnt_ff - 1'b1;
      nxt_bit = bit_ff;
      nxt_sh = sh_ff;
      nxt_sclk = sclk_ff;
      nxt_win = win_ff;
      nxt_hop = hop_ff;
      nxt_busy = busy_ff;
      case (state_ff)
         H_IDLE: begin
            if (go && ctrl_ff[CTL_SER]) begin
               nxt_busy = 1'b1;
               nxt_sh = word_ff[SER_BITS-1:0];
               nxt_bit = '0;
               nxt_win = 1'b1;
               nxt_cnt = CNT_W'(SCLK_HALF_CYC - 1);
               nxt_state = H_SCLK_LO;
            end else if (go) begin
               nxt_busy = 1'b1;
               nxt_cnt = CNT_W'(SETUP_CYC - 1);
               nxt_state = H_SETUP;
            end
         end
         H_SETUP, H_GAP: begin
            if (tick) begin
               nxt_hop = 1'b1;
               nxt_cnt = CNT_W'(HOP_CYC - 1);
               nxt_state = H_HOP_HI;
            end
         end
         H_SCLK_LO: begin
            if (tick) begin
               nxt_sclk = 1'b1;
               nxt_cnt = CNT_W'(SCLK_HALF_CYC - 1);
               nxt_state = H_SCLK_HI;
            end
         end
         H_SCLK_HI: begin
            if (tick) begin
               nxt_sclk = 1'b0;
               nxt_cnt = CNT_W'(SCLK_HALF_CYC - 1);
               if (lastBit) begin
                  nxt_win = 1'b0;
                  nxt_state = H_GAP;
               end else begin
                  nxt_bit = bit_ff + 1'b1;
                  nxt_sh = {sh_ff[SER_BITS-2:0], 1'b0};
                  nxt_state = H_SCLK_LO;
               end
            end
         end
         H_HOP_HI: begin
            if (tick) begin
               nxt_hop = 1'b0;
               nxt_cnt = CNT_W'(HOP_CYC - 1);
               nxt_state = H_HOP_LO;
            end
         end
         H_HOP_LO: begin
            if (tick) begin
               nxt_busy = 1'b0;
               nxt_state = H_IDLE;
            end
         end
         default: begin
            nxt_state = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_ff <= H_IDLE;
         cnt_ff <= '0;
         bit_ff <= '0;
         sh_ff <= '0;
         sclk_ff <= 1'b0;
         win_ff <= 1'b0;
         hop_ff <= 1'b0;
         busy_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         bit_ff <= nxt_bit;
         sh_ff <= nxt_sh;
         sclk_ff <= nxt_sclk;
         win_ff <= nxt_win;
         hop_ff <= nxt_hop;
         busy_ff <= nxt_busy;
      end
   end

   // ----------------------------------------
   // Pins
   // ----------------------------------------
   assign link.loadSourceSelect = ctrl_ff[CTL_LSEL];
   assign link.phaseBypassEn = ctrl_ff[CTL_BYP];
   assign link.sleepN = ~ctrl_ff[CTL_SLEEP];
   assign link.serialSelectN = ~ctrl_ff[CTL_SER];
   assign link.ddsResetN = ~(ctrl_ff[CTL_RST] | (rstCnt_ff != '0));
   assign link.freqTuningWord = word_ff[SER_BITS-1:0];
   assign link.serialInLine = sh_ff[SER_BITS-1];
   assign link.serialShiftClock = sclk_ff;
   assign link.shiftWindow = win_ff;
   assign link.hopStrobe = hop_ff;
endmodule

// ### verilog/ddstl_pkg.sv
package ddstl_pkg;
   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int FTW_W = 32;
   localparam int SER_BITS = 31;
   localparam int OUT_W = 14;
   localparam int PH_W = 12;
   localparam int LUT_SHIFT = 9;
   localparam logic [PH_W-1:0] LUT_MID = 12'h800;
   localparam logic [PH_W-2:0] LUT_MAX_Y = 11'h7ff;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int MCLK_NS = 5;
   localparam int SCLK_HALF_NS = 40;
   localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + MCLK_NS - 1) / MCLK_NS;
   localparam int HOP_NS = 40;
   localparam int HOP_CYC = (HOP_NS + MCLK_NS - 1) / MCLK_NS;
   localparam int SETUP_NS = 40;
   localparam int SETUP_CYC = (SETUP_NS + MCLK_NS - 1) / MCLK_NS;
   localparam int RST_NS = 100;
   localparam int RST_CYC = (RST_NS + MCLK_NS - 1) / MCLK_NS;
   localparam int CNT_W = 8;
   // ----------------------------------------
   // Host registers
   // ----------------------------------------
   localparam logic [3:0] ADR_CTRL = 4'h0;
   localparam logic [3:0] ADR_WORD = 4'h4;
   localparam logic [3:0] ADR_CMD = 4'h8;
   localparam int CTRL_W = 5;
   localparam int CTL_LSEL = 0;
   localparam int CTL_BYP = 1;
   localparam int CTL_SLEEP = 2;
   localparam int CTL_SER = 3;
   localparam int CTL_RST = 4;
   localparam logic [CTRL_W-1:0] CTRL_RST_VAL = 5'h00;
   localparam int CMD_GO = 0;
   localparam int ST_BUSY = 0;
   typedef enum {H_IDLE, H_SETUP, H_SCLK_LO, H_SCLK_HI, H_GAP, H_HOP_HI, H_HOP_LO} ddstl_hstate_e;
endpackage

// ### verilog/ddstl_if.sv
`timescale 1ns/1ps
interface ddstl_if;
   import ddstl_pkg::*;
   logic loadSourceSelect;
   logic [SER_BITS-1:0] freqTuningWord;
   logic hopStrobe;
   logic serialInLine;
   logic serialShiftClock;
   logic shiftWindow;
   logic serialSelectN;
   logic phaseBypassEn;
   logic sleepN;
   logic ddsResetN;
   logic serialChainOut;
   modport dev (
      input loadSourceSelect,
      input freqTuningWord,
      input hopStrobe,
      input serialInLine,
      input serialShiftClock,
      input shiftWindow,
      input serialSelectN,
      input phaseBypassEn,
      input sleepN,
      input ddsResetN,
      output serialChainOut
   );
   modport host (
      output loadSourceSelect,
      output freqTuningWord,
      output hopStrobe,
      output serialInLine,
      output serialShiftClock,
      output shiftWindow,
      output serialSelectN,
      output phaseBypassEn,
      output sleepN,
      output ddsResetN,
      input serialChainOut
   );
endinterface

// ### verilog/ddstl_sync.sv
`timescale 1ns/1ps
module ddstl_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   // ----------------------------------------
   // Two-stage synchroniser
   // ----------------------------------------
   logic [W-1:0] meta_ff;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         meta_ff <= RST_VAL;
         dout <= RST_VAL;
      end else begin
         meta_ff <= din;
         dout <= meta_ff;
      end
   end
endmodule

// ### verilog/ddstl_device.sv
`timescale 1ns/1ps
module ddstl_device
   import ddstl_pkg::*;
#(
   parameter int FTW_W_P = FTW_W
) (
   input wire logic mclk,
   input wire logic resetn,
   ddstl_if.dev link,
   output logic [OUT_W-1:0] sampleOut,
   output logic powerDown,
   output logic wordLoaded
);
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   localparam int SW = SER_BITS + 8;
   localparam logic [SW-1:0] SYNC_RST = {{(SER_BITS + 1){1'b0}}, 7'h45};
   wire [SW-1:0] rawIn = {
      link.loadSourceSelect,
      link.freqTuningWord,
      link.hopStrobe,
      link.serialInLine,
      link.serialShiftClock,
      link.shiftWindow,
      link.serialSelectN,
      link.phaseBypassEn,
      link.sleepN
   };
   logic [SW-1:0] syncd;

   ddstl_sync #(.W(SW), .RST_VAL(SYNC_RST)) u_sync (
      .mclk(mclk),
      .resetn(resetn),
      .din(rawIn),
      .dout(syncd)
   );

   wire loadSelS = syncd[SW-1];
   wire [SER_BITS-1:0] wordS = syncd[SW-2 -: SER_BITS];
   wire hopS = syncd[6];
   wire serInS = syncd[5];
   wire sclkS = syncd[4];
   wire winS = syncd[3];
   wire selNS = syncd[2];
   wire bypS = syncd[1];
   wire sleepNS = syncd[0];

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic hopPrev_ff;
   logic sclkPrev_ff;
   logic [SER_BITS-1:0] serBuf_ff;
   logic [FTW_W_P-1:0] tune_ff;
   logic [FTW_W_P-1:0] acc_ff;
   logic [PH_W-1:0] lut_ff;
   logic [OUT_W-1:0] out_ff;
   logic loaded_ff;

   // ----------------------------------------
   // Edge detect
   // ----------------------------------------
   wire hopRise = hopS & ~hopPrev_ff;
   wire sclkRise = sclkS & ~sclkPrev_ff;

   // ----------------------------------------
   // Load decode
   // ----------------------------------------
   wire asleep = ~sleepNS;
   wire serEn = ~selNS;
   wire shiftNow = serEn & winS & sclkRise;
   wire serLoad = serEn & ~winS & hopRise & ~asleep;
   wire parHop = ~serEn & loadSelS & hopRise & ~asleep;
   wire parSync = ~serEn & ~loadSelS & ~asleep;
   wire anyLoad = serLoad | parHop | parSync;
   wire [FTW_W_P-2:0] parWord = wordS[FTW_W_P-2:0];
   wire [FTW_W_P-2:0] serWord = serBuf_ff[FTW_W_P-2:0];
   wire [FTW_W_P-1:0] nxt_tune = serLoad ? {1'b0, serWord} :
                                 (parHop | parSync) ? {1'b0, parWord} : tune_ff;
   wire [SER_BITS-1:0] nxt_serBuf = shiftNow ? {serBuf_ff[SER_BITS-2:0], serInS} :
                                    serBuf_ff;
   wire [FTW_W_P-1:0] nxt_acc = asleep ? acc_ff : FTW_W_P'(acc_ff + tune_ff);

   // ----------------------------------------
   // Sine lookup
   // ----------------------------------------
   wire [PH_W-1:0] phase = acc_ff[FTW_W_P-1 -: PH_W];
   wire [PH_W-1:0] xq = {1'b0, phase[PH_W-2:0]};
   wire [PH_W-1:0] xc = LUT_MID - xq;
   wire [2*PH_W-1:0] prod = xq * xc;
   wire yClamp = prod[LUT_SHIFT + PH_W - 1];
   wire [PH_W-2:0] yVal = yClamp ? LUT_MAX_Y : prod[LUT_SHIFT + PH_W - 2:LUT_SHIFT];
   wire [PH_W-1:0] amp = phase[PH_W-1] ? LUT_MID - {1'b0, yVal} :
                                         LUT_MID + {1'b0, yVal};
   wire [PH_W-1:0] nxt_lut = (asleep | bypS) ? lut_ff : amp;

   // ----------------------------------------
   // Output select
   // ----------------------------------------
   wire [OUT_W-1:0] bypWord = acc_ff[FTW_W_P-1 -: OUT_W];
   wire [OUT_W-1:0] sineWord = {2'b00, lut_ff};
   wire [OUT_W-1:0] selWord = bypS ? bypWord : sineWord;
   wire [OUT_W-1:0] nxt_out = asleep ? out_ff :
                              loaded_ff ? selWord : '0;

   // ----------------------------------------
   // Edge history
   // ----------------------------------------
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         hopPrev_ff <= 1'b1;
      end else begin
         hopPrev_ff <= hopS;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sclkPrev_ff <= 1'b0;
      end else begin
         sclkPrev_ff <= sclkS;
      end
   end

   // ----------------------------------------
   // Serial buffer
   // ----------------------------------------
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         serBuf_ff <= '0;
      end else begin
         serBuf_ff <= nxt_serBuf;
      end
   end

   // ----------------------------------------
   // Tuning register
   // ----------------------------------------
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         tune_ff <= '0;
      end else begin
         tune_ff <= nxt_tune;
      end
   end

   // ----------------------------------------
   // Phase accumulator
   // ----------------------------------------
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         acc_ff <= '0;
      end else begin
         acc_ff <= nxt_acc;
      end
   end

   // ----------------------------------------
   // Lookup and output stage
   // ----------------------------------------
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         lut_ff <= '0;
      end else begin
         lut_ff <= nxt_lut;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         out_ff <= '0;
      end else begin
         out_ff <= nxt_out;
      end
   end

   // ----------------------------------------
   // Load flag
   // ----------------------------------------
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         loaded_ff <= 1'b0;
      end else begin
         loaded_ff <= loaded_ff | anyLoad;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign link.serialChainOut = serBuf_ff[SER_BITS-1];
   assign sampleOut = out_ff;
   assign powerDown = asleep;
   assign wordLoaded = loaded_ff;
endmodule

// ### verification/ddstl_asserts.sv
`timescale 1ns/1ps
// ----------------------------------------
// Link checks
// ----------------------------------------
module ddstl_asserts
   import ddstl_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic hopStrobe,
   input wire logic serialShiftClock,
   input wire logic shiftWindow,
   input wire logic serialSelectN,
   input wire logic phaseBypassEn,
   input wire logic sleepN,
   input wire logic ddsResetN,
   input wire logic [OUT_W-1:0] sampleOut,
   input wire logic powerDown
);
   logic sclkQ_ff;
   logic winQ_ff;
   logic [5:0] bits_ff;
   logic [5:0] nxt_bits;
   logic sclkRise;
   logic winRise;
   assign sclkRise = serialShiftClock & ~sclkQ_ff;
   assign winRise = shiftWindow & ~winQ_ff;
   assign nxt_bits = winRise ? 6'h00 : (sclkRise ? bits_ff + 6'h01 : bits_ff);
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sclkQ_ff <= 1'b0;
         winQ_ff <= 1'b0;
         bits_ff <= 6'h00;
      end else begin
         sclkQ_ff <= serialShiftClock;
         winQ_ff <= shiftWindow;
         bits_ff <= nxt_bits;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   AST_WORD_BITS: assert property ($fell(shiftWindow) |-> bits_ff == 6'h1f)
      else $error("serial word not 31 clocks");
   AST_SCLK_IN_WIN: assert property ($rose(serialShiftClock) |-> shiftWindow)
      else $error("shift clock outside window");
   AST_SEL_STATIC: assert property (shiftWindow |-> !serialSelectN)
      else $error("serial select not low while shifting");
   AST_HOP_AFTER_WIN: assert property ($rose(hopStrobe) && !serialSelectN |-> !shiftWindow)
      else $error("hop while window high");
   AST_HOP_HOLD: assert property ($rose(hopStrobe) |-> hopStrobe [*8])
      else $error("hop pulse too short");
   AST_RST_CLEAR: assert property (!ddsResetN |-> sampleOut == 14'h0000 && !powerDown)
      else $error("output not cleared in reset");
   AST_SLEEP_ON: assert property ((!sleepN && ddsResetN) [*4] |-> powerDown)
      else $error("power-down not entered");
   AST_SLEEP_OFF: assert property (sleepN [*4] |-> !powerDown)
      else $error("power-down not left");
   AST_SLEEP_FREEZE: assert property ((!sleepN && ddsResetN) [*5] |-> $stable(sampleOut))
      else $error("output moved in power-down");
   AST_TOP_BITS: assert property (!phaseBypassEn [*8] |-> sampleOut[13:12] == 2'h0)
      else $error("top output bits active outside bypass");
endmodule

// ### verification/testbench.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host to device bench
// ----------------------------------------
module testbench
   import ddstl_pkg::*;
;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic wbCyc = 1'b0;
   logic wbStb = 1'b0;
   logic wbWe = 1'b0;
   logic [3:0] wbAdr = 4'h0;
   logic [3:0] wbSel = 4'h0;
   logic [31:0] wbDatW = 32'h0;
   logic [31:0] wbDatR;
   logic wbAck;
   logic [31:0] rd;
   logic [OUT_W-1:0] sampleOut;
   logic [OUT_W-1:0] snap;
   logic [OUT_W-1:0] diff;
   logic powerDown;
   logic wordLoaded;
   logic devRstN;
   logic sclkQ = 1'b0;
   logic [SER_BITS-1:0] chainCap = 31'h0;
   int fails = 0;
   int checked = 0;
   always #2.5 mclk = ~mclk;
   ddstl_if ifc();
   assign devRstN = resetn & ifc.ddsResetN;
   ddstl_host ddstl_host_inst(.mclk(mclk), .resetn(resetn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
      .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR),
      .wb_ack_o(wbAck), .link(ifc));
   ddstl_device ddstl_device_inst(.mclk(mclk), .resetn(devRstN), .link(ifc),
      .sampleOut(sampleOut), .powerDown(powerDown), .wordLoaded(wordLoaded));
   ddstl_asserts ddstl_asserts_inst(.mclk(mclk), .resetn(resetn), .hopStrobe(ifc.hopStrobe),
      .serialShiftClock(ifc.serialShiftClock), .shiftWindow(ifc.shiftWindow),
      .serialSelectN(ifc.serialSelectN), .phaseBypassEn(ifc.phaseBypassEn),
      .sleepN(ifc.sleepN), .ddsResetN(ifc.ddsResetN), .sampleOut(sampleOut),
      .powerDown(powerDown));
   // Chain bit seen at each shift clock rise
   always @(posedge mclk) begin
      sclkQ <= ifc.serialShiftClock;
      if (ifc.shiftWindow && ifc.serialShiftClock && !sclkQ) begin
         chainCap <= {chainCap[SER_BITS-2:0], ifc.serialChainOut};
      end
   end
   task end_of_test;
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
      int n;
      n = 0;
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= adr;
      wbSel <= 4'hf;
      wbDatW <= dat;
      @(posedge mclk);
      while (wbAck !== 1'b1) begin
         n++;
         if (n > 50) begin
            fails++;
            $display("mismatch at %0t: bus timeout", $time);
            end_of_test;
         end
         @(posedge mclk);
      end
      rd = wbDatR;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe <= 1'b0;
      @(posedge mclk);
   endtask
   task go;
      int n;
      n = 0;
      wb(1'b1, ADR_CMD, 32'h1);
      do begin
         wb(1'b0, ADR_CMD, 32'h0);
         n++;
         if (n > 400) begin
            fails++;
            $display("mismatch at %0t: load timeout", $time);
            end_of_test;
         end
      end while (rd[ST_BUSY] !== 1'b0);
   endtask
   task step(input int k, input logic [31:0] exp, input string what);
      snap = sampleOut;
      repeat (k) @(posedge mclk);
      diff = sampleOut - snap;
      chk(32'(diff), exp, what);
   endtask
   task ctrl(input logic [31:0] v);
      wb(1'b1, ADR_CTRL, v);
      repeat (10) @(posedge mclk);
   endtask
   initial begin
      repeat (16) @(posedge mclk);
      resetn <= 1'b1;
      repeat (5) @(posedge mclk);
      chk(32'(sampleOut), 32'h0, "out in reset");
      repeat (30) @(posedge mclk);
      chk(32'(sampleOut), 32'h800, "sine of zero phase");
      chk(32'(wordLoaded), 32'h1, "sync load after reset");
      wb(1'b0, ADR_CTRL, 32'h0);
      chk(rd, 32'h0, "ctrl reset value");
      wb(1'b0, 4'hc, 32'h0);
      chk(rd, 32'h0, "unmapped read");
      ctrl(32'h3);
      wb(1'b1, ADR_WORD, 32'hffffffff);
      wb(1'b0, ADR_WORD, 32'h0);
      chk(rd, 32'h7fffffff, "word msb");
      wb(1'b1, ADR_WORD, 32'h40000);
      step(10, 32'h0, "no load without hop");
      go;
      repeat (10) @(posedge mclk);
      step(10, 32'ha, "hop load bypass");
      ctrl(32'h7);
      wb(1'b1, ADR_WORD, 32'h80000);
      go;
      step(20, 32'h0, "frozen in sleep");
      chk(32'(powerDown), 32'h1, "power-down flag");
      ctrl(32'h3);
      step(10, 32'ha, "hop ignored in sleep");
      ctrl(32'h2);
      step(10, 32'h14, "sync load");
      ctrl(32'ha);
      wb(1'b1, ADR_WORD, 32'hc0000);
      go;
      chk(32'(chainCap), 32'h0, "chain after reset");
      repeat (10) @(posedge mclk);
      step(10, 32'h1e, "serial load");
      wb(1'b1, ADR_WORD, 32'h40000);
      ctrl(32'he);
      go;
      chk(32'(chainCap), 32'hc0000, "chain old word");
      step(10, 32'h0, "serial frozen in sleep");
      ctrl(32'ha);
      step(10, 32'h1e, "transfer blocked in sleep");
      go;
      chk(32'(chainCap), 32'h40000, "buffered in sleep");
      repeat (10) @(posedge mclk);
      step(10, 32'ha, "serial reload");
      ctrl(32'h1e);
      chk(32'(sampleOut), 32'h0, "reset in sleep");
      chk(32'(wordLoaded), 32'h0, "loaded cleared");
      ctrl(32'h0);
      repeat (10) @(posedge mclk);
      chk(32'(sampleOut[13:12]), 32'h0, "top bits normal");
      end_of_test;
   end
endmodule
